// File: src/video_ctrl_pkg.sv
// Constants, field layout and carrier types for the decoder control register group
package video_ctrl_pkg;

   // ==========================================================
   // Register entries, printed indices and chosen indices
   // ==========================================================
   localparam int NREG = 8;
   localparam int E_MISC = 0;
   localparam int E_MASK = 1;
   localparam int E_KILL = 2;
   localparam int E_LUMA1 = 3;
   localparam int E_LUMA2 = 4;
   localparam int E_BRIGHT = 5;
   localparam int E_SAT = 6;
   localparam int E_AUX = 7;
   localparam logic [7:0] IDX_MISC = 8'h03;
   localparam logic [7:0] IDX_MASK = 8'h04;
   localparam logic [7:0] IDX_KILL = 8'h06;
   localparam logic [7:0] IDX_LUMA1 = 8'h07;
   localparam logic [7:0] IDX_LUMA2 = 8'h08;
   localparam logic [7:0] IDX_BRIGHT = 8'h09;
   localparam logic [7:0] IDX_SAT = 8'h0A;
   localparam logic [7:0] IDX_AUX = 8'h10;
   localparam logic [7:0] IDX_STATUS = 8'h11;
   localparam logic [NREG-1:0][7:0] REG_INDEX = {IDX_AUX, IDX_SAT, IDX_BRIGHT,
      IDX_LUMA2, IDX_LUMA1, IDX_KILL, IDX_MASK, IDX_MISC};

   // ==========================================================
   // Reset values and writable bits
   // ==========================================================
   localparam logic [7:0] RST_MASK_SECAM_ON = 8'hDC;
   localparam logic [NREG-1:0][7:0] REG_RESET = {8'h07, 8'h80, 8'h80,
      8'h00, 8'h60, 8'h10, 8'hFC, 8'h01};
   localparam logic [NREG-1:0][7:0] REG_WMASK = {8'h0F, 8'hFF, 8'hFF,
      8'h4F, 8'hFF, 8'h7F, 8'h3C, 8'hFF};

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int MISC_PIN27_VBLANK = 7;
   localparam int MISC_GP_LEVEL = 6;
   localparam int MISC_GP_EN = 5;
   localparam int MISC_LOCK_SEL = 4;
   localparam int MISC_PIX_EN = 3;
   localparam int MISC_SYNC_EN = 2;
   localparam int MISC_VBLANK_ON = 1;
   localparam int MISC_CLK_EN = 0;
   localparam int MASK_LSB = 2;
   localparam int KILL_MODE_LSB = 5;
   localparam int LUMA1_DOUBLE = 7;
   localparam int LUMA1_NO_PEDESTAL = 6;
   localparam int LUMA1_NO_HEADER = 5;
   localparam int LUMA1_VBI_BYPASS = 4;
   localparam int LUMA2_TRAP = 6;
   localparam int LUMA2_PEAK_LSB = 2;
   localparam int AUX_VBI_PIX_EN = 0;
   localparam int AUX_PIN27_SHARED = 1;
   localparam int AUX_PIN24_PAL = 2;
   localparam int AUX_PIN23_FIELD = 3;

   // ==========================================================
   // Codes and types
   // ==========================================================
   localparam logic [1:0] KILL_FORCE = 2'h2;
   localparam logic [1:0] KILL_OFF = 2'h3;
   localparam logic [1:0] AGC_FORCE_OFF = 2'h2;
   localparam logic [1:0] AGC_FORCE_ON = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {WR_ACCEPT, WR_COMMIT, WR_RESPOND} wr_state_t;

   typedef struct packed {
      logic [3:0] standardMask;
      logic killerAuto;
      logic killerForce;
      logic killerDisable;
      logic [4:0] killerThreshold;
      logic lumaDoubleRate;
      logic pedestalAbsent;
      logic rawHeaderSuppress;
      logic [3:0] lumaDelay;
      logic chromaTrapSelect;
      logic [1:0] peakingGain;
      logic agcAuto;
      logic agcDetectOn;
      logic [7:0] brightness;
      logic [7:0] saturation;
   } ctrl_t;

endpackage

// File: src/video_output_luma_ctrl.sv
// Register group for output enables, shared pins, autoswitch masks and luma control
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps

// Functional notes
// - General-purpose pin drives bit 6 level while bit 5 enables it; both reset 0.
// - Lock select 0 passes PAL and field signals; 1 passes lock flags.
// - Local pixel bus enable bit 3 resets 0, zero keeps bus released.
// - Bit 2 enables sync, PAL, active video and field outputs; reset 0.
// - Bit 1 turns vertical blank indication on; reset off.
// - Bit 0 enables pixel clock output; reset 1.
// - Pixel bus active only when local and VBI enables both set.
// - Each autoswitch mask bit set excludes its standard.
// - Mask resets FCh or DCh depending on device variant.
// - Killer mode: 00 automatic, 10 forced zero colour, 11 disabled.
// - Five-bit killer threshold, reset 10000.
// - Luma bit 7 forces double-rate luma all frame, over bit 4.
// - Bit 4 gives double-rate luma only during vertical blanking.
// - Bit 6 flags pedestal absent; reset 1.
// - Bit 5 suppresses raw ancillary headers; reset 1.
// - Four-bit signed luma delay, reset 0000.
// - Second luma bit 6 selects chroma trap instead of comb.
// - Two-bit peaking gain, reset 00.
// - AGC detect codes 00/01 auto, 10 forced off, 11 forced on.
// - Brightness eight bits, reset 128.
// - Saturation eight bits, reset 128.
// - Shared pin 27: bit 7 picks general-purpose or vertical blank.
module video_output_luma_ctrl #(
   parameter int ADDR_W = 10,
   parameter bit SECAM_MASKED = 1'b1
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic inVerticalBlank,
   input wire logic verticalSync,
   input wire logic palLineIndicator,
   input wire logic fieldIdentifier,
   input wire logic genlockControlOut,
   input wire logic horizontalLockFlag,
   input wire logic verticalLockFlag,
   output video_ctrl_pkg::ctrl_t ctrl,
   output logic pixelBusOe,
   output logic syncOutputsOe,
   output logic clockOutOe,
   output logic verticalBlankIndication,
   output logic sharedPin27Out,
   output logic sharedPin27Oe,
   output logic pin24Out,
   output logic pin23Out
);

   // ==========================================================
   // Elaboration check
   // ==========================================================
   // Indices are taken from address bits 9:2, so the byte address needs at least ten bits
   if (ADDR_W < 10) begin : g_bad_width
      $error("ADDR_W must be at least 10");
   end

   // ==========================================================
   // Write channel
   // ==========================================================
   video_ctrl_pkg::wr_state_t wState;
   logic [7:0] wrIndex, wrData, rdIndex, rdValue, statusValue;
   logic wrAligned, wrLane, rdMapped;
   logic [video_ctrl_pkg::NREG-1:0][7:0] regs;
   logic [video_ctrl_pkg::NREG-1:0] wrHit, rdHit;

   // Address and data may arrive in either order; each is held once taken
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wState <= video_ctrl_pkg::WR_ACCEPT;
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= video_ctrl_pkg::RESP_OKAY;
         wrIndex <= 8'h00;
         wrAligned <= 1'b0;
         wrData <= 8'h00;
         wrLane <= 1'b0;
      end else begin
         case (wState)
            video_ctrl_pkg::WR_ACCEPT: begin
               if (awvalid && awready) begin
                  wrIndex <= awaddr[9:2];
                  wrAligned <= (awaddr[1:0] == 2'h0) && ((awaddr >> 10) == '0);
                  awready <= 1'b0;
               end
               if (wvalid && wready) begin
                  wrData <= wdata[7:0];
                  wrLane <= wstrb[0];
                  wready <= 1'b0;
               end
               if ((!awready || awvalid) && (!wready || wvalid)) begin
                  wState <= video_ctrl_pkg::WR_COMMIT;
               end
            end
            video_ctrl_pkg::WR_COMMIT: begin
               bvalid <= 1'b1;
               bresp <= (wrAligned && (|wrHit || wrIndex == video_ctrl_pkg::IDX_STATUS)) ?
                  video_ctrl_pkg::RESP_OKAY : video_ctrl_pkg::RESP_SLVERR;
               wState <= video_ctrl_pkg::WR_RESPOND;
            end
            video_ctrl_pkg::WR_RESPOND: begin
               if (bready) begin
                  bvalid <= 1'b0;
                  awready <= 1'b1;
                  wready <= 1'b1;
                  wState <= video_ctrl_pkg::WR_ACCEPT;
               end
            end
            default: begin
               wState <= video_ctrl_pkg::WR_ACCEPT;
            end
         endcase
      end
   end

   // ==========================================================
   // Register storage
   // ==========================================================
   // The mask register default depends on the device variant
   localparam logic [7:0] MASK_RESET = SECAM_MASKED ?
      video_ctrl_pkg::REG_RESET[video_ctrl_pkg::E_MASK] : video_ctrl_pkg::RST_MASK_SECAM_ON;

   for (genvar i = 0; i < video_ctrl_pkg::NREG; i++) begin : g_reg
      localparam logic [7:0] RST_VAL = (i == video_ctrl_pkg::E_MASK) ?
         MASK_RESET : video_ctrl_pkg::REG_RESET[i];
      assign wrHit[i] = wrIndex == video_ctrl_pkg::REG_INDEX[i];
      assign rdHit[i] = rdIndex == video_ctrl_pkg::REG_INDEX[i];
      always_ff @(posedge clk_sys) begin
         if (!rstn) begin
            regs[i] <= RST_VAL;
         end else if (wState == video_ctrl_pkg::WR_COMMIT && wrLane && wrAligned && wrHit[i]) begin
            regs[i] <= wrData & video_ctrl_pkg::REG_WMASK[i];
         end
      end
   end

   // ==========================================================
   // Read channel
   // ==========================================================
   assign rdIndex = araddr[9:2];
   assign statusValue = {5'h00, sharedPin27Oe, ctrl.lumaDoubleRate, pixelBusOe};

   always_comb begin
      rdValue = 8'h00;
      rdMapped = (araddr[1:0] == 2'h0) && ((araddr >> 10) == '0);
      if (rdIndex == video_ctrl_pkg::IDX_STATUS) begin
         rdValue = statusValue;
      end else if (|rdHit) begin
         for (int k = 0; k < video_ctrl_pkg::NREG; k++) begin
            if (rdHit[k]) begin
               rdValue = regs[k];
            end
         end
      end else begin
         rdMapped = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= video_ctrl_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rdMapped ? {24'h000000, rdValue} : 32'h0000_0000;
         rresp <= rdMapped ? video_ctrl_pkg::RESP_OKAY : video_ctrl_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // ==========================================================
   // Output pin control
   // ==========================================================
   logic [7:0] misc, aux;
   assign misc = regs[video_ctrl_pkg::E_MISC];
   assign aux = regs[video_ctrl_pkg::E_AUX];

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pixelBusOe <= 1'b0;
         syncOutputsOe <= 1'b0;
         clockOutOe <= 1'b1;
         verticalBlankIndication <= 1'b0;
      end else begin
         pixelBusOe <= misc[video_ctrl_pkg::MISC_PIX_EN] & aux[video_ctrl_pkg::AUX_VBI_PIX_EN];
         syncOutputsOe <= misc[video_ctrl_pkg::MISC_SYNC_EN];
         clockOutOe <= misc[video_ctrl_pkg::MISC_CLK_EN];
         verticalBlankIndication <= misc[video_ctrl_pkg::MISC_VBLANK_ON];
      end
   end

   // Pin 27 is released when it carries the interrupt function, which lives elsewhere
   always_ff @(posedge clk_sys) begin
      if (!rstn || !aux[video_ctrl_pkg::AUX_PIN27_SHARED]) begin
         sharedPin27Out <= 1'b0;
         sharedPin27Oe <= 1'b0;
      end else if (misc[video_ctrl_pkg::MISC_PIN27_VBLANK]) begin
         sharedPin27Out <= misc[video_ctrl_pkg::MISC_VBLANK_ON] & inVerticalBlank;
         sharedPin27Oe <= 1'b1;
      end else begin
         sharedPin27Out <= misc[video_ctrl_pkg::MISC_GP_LEVEL];
         sharedPin27Oe <= misc[video_ctrl_pkg::MISC_GP_EN];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pin24Out <= 1'b0;
         pin23Out <= 1'b0;
      end else begin
         if (!aux[video_ctrl_pkg::AUX_PIN24_PAL]) begin
            pin24Out <= verticalSync;
         end else if (misc[video_ctrl_pkg::MISC_LOCK_SEL]) begin
            pin24Out <= horizontalLockFlag;
         end else begin
            pin24Out <= palLineIndicator;
         end
         if (!aux[video_ctrl_pkg::AUX_PIN23_FIELD]) begin
            pin23Out <= genlockControlOut;
         end else if (misc[video_ctrl_pkg::MISC_LOCK_SEL]) begin
            pin23Out <= verticalLockFlag;
         end else begin
            pin23Out <= fieldIdentifier;
         end
      end
   end

   // ==========================================================
   // Processing controls
   // ==========================================================
   logic [7:0] kill, luma1, luma2;
   assign kill = regs[video_ctrl_pkg::E_KILL];
   assign luma1 = regs[video_ctrl_pkg::E_LUMA1];
   assign luma2 = regs[video_ctrl_pkg::E_LUMA2];

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ctrl <= '0;
      end else begin
         ctrl.standardMask <= regs[video_ctrl_pkg::E_MASK][video_ctrl_pkg::MASK_LSB +: 4];
         // killer mode decode, reserved code treated as automatic
         ctrl.killerForce <= kill[video_ctrl_pkg::KILL_MODE_LSB +: 2] == video_ctrl_pkg::KILL_FORCE;
         ctrl.killerDisable <= kill[video_ctrl_pkg::KILL_MODE_LSB +: 2] == video_ctrl_pkg::KILL_OFF;
         ctrl.killerAuto <= !kill[video_ctrl_pkg::KILL_MODE_LSB + 1];
         ctrl.killerThreshold <= kill[4:0];
         ctrl.lumaDoubleRate <= luma1[video_ctrl_pkg::LUMA1_DOUBLE] |
            (luma1[video_ctrl_pkg::LUMA1_VBI_BYPASS] & inVerticalBlank);
         ctrl.pedestalAbsent <= luma1[video_ctrl_pkg::LUMA1_NO_PEDESTAL];
         ctrl.rawHeaderSuppress <= luma1[video_ctrl_pkg::LUMA1_NO_HEADER];
         ctrl.lumaDelay <= luma1[3:0];
         ctrl.chromaTrapSelect <= luma2[video_ctrl_pkg::LUMA2_TRAP];
         ctrl.peakingGain <= luma2[video_ctrl_pkg::LUMA2_PEAK_LSB +: 2];
         ctrl.agcAuto <= !luma2[1];
         ctrl.agcDetectOn <= luma2[1:0] == video_ctrl_pkg::AGC_FORCE_ON;
         ctrl.brightness <= regs[video_ctrl_pkg::E_BRIGHT];
         ctrl.saturation <= regs[video_ctrl_pkg::E_SAT];
      end
   end

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   property p_pix_oe;
      pixelBusOe |-> $past(misc[3]) && $past(aux[0]);
   endproperty
   a_pix_oe: assert property (p_pix_oe) else $error("pixel bus on without both enables");
   property p_clk_oe;
      $fell(misc[0]) |=> !clockOutOe;
   endproperty
   a_clk_oe: assert property (p_clk_oe) else $error("clock output not released");
   property p_sync_oe;
      misc[2] ##1 misc[2] |-> syncOutputsOe;
   endproperty
   a_sync_oe: assert property (p_sync_oe) else $error("sync outputs not driven");
   property p_gp_pin;
      aux[1] && !misc[7] |=> sharedPin27Oe == $past(misc[5]) &&
         (!sharedPin27Oe || sharedPin27Out == $past(misc[6]));
   endproperty
   a_gp_pin: assert property (p_gp_pin) else $error("general-purpose pin wrong");
   property p_lock_swap;
      aux[2] && misc[4] |=> pin24Out == $past(horizontalLockFlag);
   endproperty
   a_lock_swap: assert property (p_lock_swap) else $error("lock flag not on pin 24");
   property p_luma_double;
      luma1[7] ##1 luma1[7] |-> ctrl.lumaDoubleRate;
   endproperty
   a_luma_double: assert property (p_luma_double) else $error("double rate not forced");
   property p_luma_active;
      !luma1[7] && !inVerticalBlank |=> !ctrl.lumaDoubleRate;
   endproperty
   a_luma_active: assert property (p_luma_active) else $error("double rate in active video");
   property p_killer;
      kill[6:5] == 2'h2 |=> ctrl.killerForce && !ctrl.killerAuto && !ctrl.killerDisable;
   endproperty
   a_killer: assert property (p_killer) else $error("forced killer not decoded");
   property p_agc;
      luma2[1:0] == 2'h1 |=> ctrl.agcAuto && !ctrl.agcDetectOn;
   endproperty
   a_agc: assert property (p_agc) else $error("agc code 01 not automatic");
   property p_write_lands;
      wState == video_ctrl_pkg::WR_COMMIT && wrLane && wrAligned && wrHit[video_ctrl_pkg::E_SAT]
         |=> regs[video_ctrl_pkg::E_SAT] == $past(wrData) ##1 ctrl.saturation == $past(wrData, 2);
   endproperty
   a_write_lands: assert property (p_write_lands) else $error("saturation write lost");
   property p_reset_vals;
      $rose(rstn) |-> regs[video_ctrl_pkg::E_BRIGHT] == 8'h80 && misc == 8'h01;
   endproperty
   a_reset_vals: assert property (disable iff (1'b0) p_reset_vals)
      else $error("reset defaults wrong");

   c_write: cover property (bvalid && bready && bresp == video_ctrl_pkg::RESP_OKAY);
   c_read_err: cover property (rvalid && rresp == video_ctrl_pkg::RESP_SLVERR);
   c_pix_on: cover property ($rose(pixelBusOe));
   c_pin27_blank: cover property (sharedPin27Oe && misc[7]);

endmodule

// File: tb/video_output_luma_ctrl_tb_top.sv
// Self-checking bench for the output enable and luma control register group
`timescale 1ns/10ps
module video_output_luma_ctrl_tb_top;
   // ==========================================================
   // Signals and tables
   // ==========================================================
   localparam logic [7:0] IX [8] = '{8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h10};
   localparam logic [7:0] RV [8] = '{8'h01, 8'hFC, 8'h10, 8'h60, 8'h00, 8'h80, 8'h80, 8'h07};
   localparam logic [7:0] WM [8] = '{8'hFF, 8'h3C, 8'h7F, 8'hFF, 8'h4F, 8'hFF, 8'hFF, 8'h0F};
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [9:0] awaddr = '0;
   logic awvalid = 1'b0;
   logic [31:0] wdata = '0;
   logic wvalid = 1'b0;
   logic [9:0] araddr = '0;
   logic arvalid = 1'b0;
   logic [6:0] vin = '0;
   logic awready, wready, bvalid, arready, rvalid;
   logic pixelBusOe, syncOutputsOe, clockOutOe, verticalBlankIndication;
   logic sharedPin27Out, sharedPin27Oe, pin24Out, pin23Out;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [31:0] rdataVariant;
   video_ctrl_pkg::ctrl_t ctrl;
   logic [7:0] d [8];
   logic [1:0] bq [$];
   logic [33:0] rq [$];
   logic [33:0] e;
   int n_fail = 0;
   int n_tests = 0;

   always #20 clk_sys = ~clk_sys;

   video_output_luma_ctrl uut (.clk_sys(clk_sys), .rstn(rstn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(1'b1), .inVerticalBlank(vin[6]), .verticalSync(vin[5]),
      .palLineIndicator(vin[4]), .fieldIdentifier(vin[3]), .genlockControlOut(vin[2]),
      .horizontalLockFlag(vin[1]), .verticalLockFlag(vin[0]), .ctrl(ctrl),
      .pixelBusOe(pixelBusOe), .syncOutputsOe(syncOutputsOe), .clockOutOe(clockOutOe),
      .verticalBlankIndication(verticalBlankIndication), .sharedPin27Out(sharedPin27Out),
      .sharedPin27Oe(sharedPin27Oe), .pin24Out(pin24Out), .pin23Out(pin23Out));

   // Second variant runs in step on the same inputs; only its read data is looked at
   video_output_luma_ctrl #(.SECAM_MASKED(1'b0)) uutVariant (.clk_sys(clk_sys), .rstn(rstn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(), .wdata(wdata), .wstrb(4'hF),
      .wvalid(wvalid), .wready(), .bresp(), .bvalid(), .bready(1'b1), .araddr(araddr),
      .arvalid(arvalid), .arready(), .rdata(rdataVariant), .rresp(), .rvalid(),
      .rready(1'b1), .inVerticalBlank(vin[6]), .verticalSync(vin[5]),
      .palLineIndicator(vin[4]), .fieldIdentifier(vin[3]), .genlockControlOut(vin[2]),
      .horizontalLockFlag(vin[1]), .verticalLockFlag(vin[0]), .ctrl(), .pixelBusOe(),
      .syncOutputsOe(), .clockOutOe(), .verticalBlankIndication(), .sharedPin27Out(),
      .sharedPin27Oe(), .pin24Out(), .pin23Out());

   // ==========================================================
   // Compare, verdict and bus tasks
   // ==========================================================
   task automatic chk(input string n, input logic [63:0] ex, input logic [63:0] got);
      n_tests++;
      if (got !== ex) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", n, ex, got);
      end
   endtask

   task automatic test_done();
      if (n_fail == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Address and data are released on their own handshakes
   task automatic wr(input logic [7:0] ix, input logic [7:0] dt, input logic [1:0] er);
      logic a;
      logic w;
      a = 1'b0;
      w = 1'b0;
      bq.push_back(er);
      awaddr <= {ix, 2'b00};
      wdata <= {24'h000000, dt};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(a && w)) begin
         @(posedge clk_sys);
         if (!a && awready) begin
            a = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w && wready) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk_sys); while (!bvalid);
   endtask

   task automatic rd(input logic [7:0] ix, input logic [7:0] dt, input logic [1:0] er);
      rq.push_back({24'h000000, dt, er});
      araddr <= {ix, 2'b00};
      arvalid <= 1'b1;
      do @(posedge clk_sys); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk_sys); while (!rvalid);
   endtask

   // Blank indication is judged only inside blanking; pin 27 level only while driven
   task automatic chkOut();
      logic [7:0] p;
      video_ctrl_pkg::ctrl_t c;
      p[7] = d[0][3] & d[7][0];
      p[6] = d[0][2];
      p[5] = d[0][0];
      p[4] = d[0][1] | ~vin[6];
      p[2] = d[7][1] & (d[0][7] | d[0][5]);
      p[3] = p[2] & (d[0][7] ? (d[0][1] & vin[6]) : d[0][6]);
      p[1] = d[7][2] ? (d[0][4] ? vin[1] : vin[4]) : vin[5];
      p[0] = d[7][3] ? (d[0][4] ? vin[0] : vin[3]) : vin[2];
      c = {d[1][5:2], ~d[2][6], d[2][6:5] == 2'b10, d[2][6:5] == 2'b11, d[2][4:0],
         d[3][7] | (d[3][4] & vin[6]), d[3][6], d[3][5], d[3][3:0], d[4][6], d[4][3:2],
         ~d[4][1], d[4][1:0] == 2'b11, d[5], d[6]};
      chk("pins", p, {pixelBusOe, syncOutputsOe, clockOutOe, verticalBlankIndication | ~vin[6],
         sharedPin27Out & p[2], sharedPin27Oe, pin24Out, pin23Out});
      chk("ctrl", c, ctrl);
   endtask

   // Defaults after any reset; the mask default tells the two variants apart
   task automatic chkDefaults();
      for (int j = 0; j < 8; j++) d[j] = RV[j];
      for (int j = 0; j < 8; j++) rd(IX[j], RV[j], video_ctrl_pkg::RESP_OKAY);
      rd(IX[1], RV[1], video_ctrl_pkg::RESP_OKAY);
      chk("rdataVariant", {24'h000000, video_ctrl_pkg::RST_MASK_SECAM_ON},
         rdataVariant);
      chkOut();
   endtask

   // ==========================================================
   // Response watcher
   // ==========================================================
   always @(posedge clk_sys) begin
      if (bvalid) begin
         chk("bresp", bq.pop_front(), bresp);
      end
      if (rvalid) begin
         e = rq.pop_front();
         chk("rdata", e[33:2], rdata);
         chk("rresp", e[1:0], rresp);
      end
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      test_done();
   end

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      void'($urandom(57));
      for (int j = 0; j < 8; j++) d[j] = RV[j];
      repeat (12) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chkDefaults();
      wr(8'h05, 8'hFF, video_ctrl_pkg::RESP_SLVERR);
      rd(8'h05, 8'h00, video_ctrl_pkg::RESP_SLVERR);
      wr(video_ctrl_pkg::IDX_STATUS, 8'hFF, video_ctrl_pkg::RESP_OKAY);
      rd(video_ctrl_pkg::IDX_STATUS, 8'h00, video_ctrl_pkg::RESP_OKAY);
      for (int i = 0; i < 16; i++) begin
         for (int j = 0; j < 8; j++) d[j] = 8'($urandom);
         d[2][6:5] = i[1:0];
         d[4][1:0] = i[3:2];
         d[3][7] = i[0];
         d[3][4] = i[1];
         if (d[7][1]) d[0][6] = 1'b1;
         vin <= {i[2], 6'($urandom)};
         wr(IX[7], d[7], video_ctrl_pkg::RESP_OKAY);
         for (int j = 0; j < 7; j++) wr(IX[j], d[j], video_ctrl_pkg::RESP_OKAY);
         for (int j = 0; j < 8; j++) rd(IX[j], d[j] & WM[j], video_ctrl_pkg::RESP_OKAY);
         chkOut();
         rd(video_ctrl_pkg::IDX_STATUS, {5'h00, d[7][1] & (d[0][7] | d[0][5]),
            d[3][7] | (d[3][4] & vin[6]), d[0][3] & d[7][0]}, video_ctrl_pkg::RESP_OKAY);
      end
      // Reset again in mid-run: all state must return to its defaults
      rstn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chkDefaults();
      wr(IX[0], 8'h01, video_ctrl_pkg::RESP_OKAY);
      repeat (2) @(posedge clk_sys);
      chk("clockOutOe", 1'b1, clockOutOe);
      test_done();
   end
endmodule
